// File: design/flash_access_pkg.sv
// Shared constants, opcodes and sector decode for the flash access block.
package flash_access_pkg;

  localparam int          SECTOR_BYTES  = 4096;
  localparam int          SMALL_KB      = 4;
  localparam int          MID_KB        = 8;
  localparam logic [16:0] ADDR_TOP      = 17'h1_0000;
  localparam logic [15:0] SECTOR0_BASE  = 16'hF000;
  localparam logic [15:0] SECTOR1_BASE  = 16'hE000;
  localparam int          FRAME_BITS    = 32;
  localparam int          TX_BITS       = 8;
  localparam logic [7:0]  GUARD_KEY1    = 8'h56;
  localparam logic [7:0]  GUARD_KEY2    = 8'hAE;
  localparam logic        RP_RESET      = 1'h1;

  typedef enum logic [7:0] {
    OP_PROG       = 8'h01,
    OP_SECT_ERASE = 8'h02,
    OP_MASS_ERASE = 8'h03,
    OP_OPT_WRITE  = 8'h04,
    OP_READ       = 8'h05,
    OP_RAM_WR     = 8'h06,
    OP_RAM_RUN    = 8'h07
  } op_type;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_WAIT     = 4'h2,
    ST_RP_ERASE = 4'h4,
    ST_READ     = 4'h8
  } state_type;

  // Returns {inside_array, sector_index}; the array ends at the top of the address space.
  function automatic logic [2:0] sector_of(input logic [15:0] addr, input logic [16:0] base);
    logic [1:0] idx;
    idx = (addr >= SECTOR0_BASE) ? 2'h0 : (addr >= SECTOR1_BASE) ? 2'h1 : 2'h2;
    sector_of = {({1'b0, addr} >= base), idx};
  endfunction

endpackage

// File: design/flash_sector_protect_access.sv
// Access, sector protection and read-out protection controller for the sectored flash.
// What this block does
// - Mass or sector erase, byte-wide programming.
// - Sector erase touches only its sector.
// - Unprotected tool and link sessions reach every sector.
// - Application programming excludes sector zero.
// - Two 4K sectors on top, sector zero F000h.
// - Sector count follows array size.
// - Protection blocks external reads and writes.
// - Removing protection mass erases first.
// - Option bit holds the protection state.
// - Key sequence arms each application request.
// - Test mode loads and runs RAM code.
// - One clock line, one shared data line.
// - Tool present reserves both link pins.
// - Sector zero stays locked for application programming.
`timescale 1ns/1ps
module flash_sector_protect_access #(
  parameter int FLASH_KB = 16
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        icc_serial_clock_in,
  input  wire logic        icc_serial_data_in,
  input  wire logic        programming_voltage_select_in,
  input  wire logic        tool_detect_in,
  input  wire logic        tool_socket_in,
  input  wire logic        rp_option_in,
  input  wire logic        cpu_req_in,
  input  wire logic [7:0]  cpu_op_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic [7:0]  cpu_data_in,
  input  wire logic        cpu_key_wr_in,
  input  wire logic [7:0]  cpu_key_in,
  input  wire logic        fl_done_in,
  input  wire logic [7:0]  fl_rdata_in,
  output logic [15:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  output logic [1:0]       fl_sector_out,
  output logic             fl_prog_out,
  output logic             fl_sector_erase_out,
  output logic             fl_mass_erase_out,
  output logic             fl_opt_prog_out,
  output logic             fl_rd_out,
  output logic             ram_we_out,
  output logic             ict_run_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             reject_out,
  output logic             readout_protect_out,
  output logic             icc_pins_reserved_out,
  output logic             icc_serial_data_out,
  output logic             icc_data_oe_n_out
);
  localparam logic [16:0] FLASH_BASE =
    17'(flash_access_pkg::ADDR_TOP - 17'(FLASH_KB * (flash_access_pkg::SECTOR_BYTES / flash_access_pkg::SMALL_KB)));
  localparam logic [1:0]  MAX_SECTOR = (FLASH_KB <= flash_access_pkg::SMALL_KB) ? 2'h0 :
                                       (FLASH_KB <= flash_access_pkg::MID_KB) ? 2'h1 : 2'h2;

  icc_link_if link ();
  flash_access_pkg::state_type state;
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic        icc_mode;
  logic        tool_present;
  logic        ext_mode;
  logic        armed;
  logic        key_stage;
  logic        rp_loaded;
  logic        op_ext;
  logic [7:0]  op_reg;
  logic        req_valid;
  logic        req_ext;
  logic [7:0]  req_op;
  logic [15:0] req_addr;
  logic [7:0]  req_data;
  logic [2:0]  sect;
  logic        permit;
  logic        cpu_unarmed;

  icc_serial_port icc_serial_port_inst (
    .mclk_in             (mclk_in),
    .rst_n_in            (rst_n_in),
    .icc_serial_clock_in (icc_serial_clock_in),
    .icc_serial_data_in  (icc_serial_data_in),
    .icc_serial_data_out (icc_serial_data_out),
    .icc_data_oe_n_out   (icc_data_oe_n_out),
    .link                (link.serial)
  );

  // Pins from the tool are asynchronous to the system clock.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {tool_socket_in, tool_detect_in, programming_voltage_select_in};
      pin_sync <= pin_meta;
    end
  end

  assign icc_mode     = pin_sync[0];
  assign tool_present = pin_sync[1];
  assign ext_mode     = pin_sync[0] | pin_sync[2];

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      icc_pins_reserved_out <= 1'b0;
      link.session          <= 1'b0;
    end else begin
      icc_pins_reserved_out <= tool_present | ext_mode;
      link.session          <= ext_mode;
    end
  end

  // While a tool owns the part, software requests are ignored without a refusal pulse.
  always_comb begin
    req_ext     = ext_mode;
    cpu_unarmed = !ext_mode && cpu_req_in && !armed;
    if (ext_mode) begin
      req_valid = link.frame_valid;
      req_op    = link.frame[31:24];
      req_addr  = link.frame[23:8];
      req_data  = link.frame[7:0];
    end else begin
      req_valid = cpu_req_in && armed;
      req_op    = cpu_op_in;
      req_addr  = cpu_addr_in;
      req_data  = cpu_data_in;
    end
  end

  assign sect = flash_access_pkg::sector_of(req_addr, FLASH_BASE);
  always_comb begin
    permit = 1'b0;
    case (req_op)
      flash_access_pkg::OP_PROG,
      flash_access_pkg::OP_SECT_ERASE: permit = sect[2] && (req_ext ? !readout_protect_out : sect[1:0] != 2'h0);
      flash_access_pkg::OP_MASS_ERASE: permit = req_ext && !readout_protect_out;
      flash_access_pkg::OP_OPT_WRITE,
      flash_access_pkg::OP_READ:       permit = req_ext;
      flash_access_pkg::OP_RAM_WR,
      flash_access_pkg::OP_RAM_RUN:    permit = req_ext && icc_mode && !readout_protect_out;
      default:                         permit = 1'b0;
    endcase
  end

  // two-key arming
  // One arming covers one request, so a stray write can never start a second operation.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || ext_mode) begin
      armed     <= 1'b0;
      key_stage <= 1'b0;
    end else if (cpu_req_in) begin
      armed     <= 1'b0;
      key_stage <= 1'b0;
    end else if (cpu_key_wr_in) begin
      if (key_stage && cpu_key_in == flash_access_pkg::GUARD_KEY2) begin
        armed     <= 1'b1;
        key_stage <= 1'b0;
      end else begin
        key_stage <= (cpu_key_in == flash_access_pkg::GUARD_KEY1);
      end
    end
  end

  // Operation sequencer; every flash strobe is a one-cycle pulse.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state               <= flash_access_pkg::ST_IDLE;
      readout_protect_out <= flash_access_pkg::RP_RESET;
      rp_loaded           <= 1'b0;
      op_ext              <= 1'b0;
      op_reg              <= 8'h00;
      mem_addr_out        <= 16'h0000;
      mem_wdata_out       <= 8'h00;
      fl_sector_out       <= 2'h0;
      fl_prog_out         <= 1'b0;
      fl_sector_erase_out <= 1'b0;
      fl_mass_erase_out   <= 1'b0;
      fl_opt_prog_out     <= 1'b0;
      fl_rd_out           <= 1'b0;
      ram_we_out          <= 1'b0;
      ict_run_out         <= 1'b0;
      busy_out            <= 1'b0;
      done_out            <= 1'b0;
      reject_out          <= 1'b0;
      link.tx_load        <= 1'b0;
      link.tx_byte        <= 8'h00;
    end else begin
      fl_prog_out         <= 1'b0;
      fl_sector_erase_out <= 1'b0;
      fl_mass_erase_out   <= 1'b0;
      fl_opt_prog_out     <= 1'b0;
      fl_rd_out           <= 1'b0;
      ram_we_out          <= 1'b0;
      ict_run_out         <= 1'b0;
      done_out            <= 1'b0;
      link.tx_load        <= 1'b0;
      reject_out          <= cpu_unarmed || (req_valid && (state != flash_access_pkg::ST_IDLE || !permit));
      if (!rp_loaded) begin
        rp_loaded           <= 1'b1;
        readout_protect_out <= rp_option_in;
      end
      unique case (state)
        flash_access_pkg::ST_IDLE: begin
          if (req_valid && permit && rp_loaded) begin
            op_ext        <= req_ext;
            op_reg        <= req_op;
            mem_addr_out  <= req_addr;
            mem_wdata_out <= req_data;
            fl_sector_out <= sect[1:0];
            busy_out      <= 1'b1;
            state         <= flash_access_pkg::ST_WAIT;
            case (req_op)
              flash_access_pkg::OP_PROG:       fl_prog_out <= 1'b1;
              flash_access_pkg::OP_SECT_ERASE: fl_sector_erase_out <= 1'b1;
              flash_access_pkg::OP_MASS_ERASE: fl_mass_erase_out <= 1'b1;
              flash_access_pkg::OP_OPT_WRITE: begin
                if (readout_protect_out && !req_data[0]) begin
                  fl_mass_erase_out <= 1'b1;
                  state             <= flash_access_pkg::ST_RP_ERASE;
                end else begin
                  fl_opt_prog_out <= 1'b1;
                end
              end
              flash_access_pkg::OP_READ: begin
                if (readout_protect_out) begin
                  link.tx_load <= 1'b1;
                  link.tx_byte <= 8'h00;
                  done_out     <= 1'b1;
                  busy_out     <= 1'b0;
                  state        <= flash_access_pkg::ST_IDLE;
                end else begin
                  fl_rd_out <= 1'b1;
                  state     <= flash_access_pkg::ST_READ;
                end
              end
              default: begin
                ram_we_out  <= (req_op == flash_access_pkg::OP_RAM_WR);
                ict_run_out <= (req_op == flash_access_pkg::OP_RAM_RUN);
                done_out    <= 1'b1;
                busy_out    <= 1'b0;
                state       <= flash_access_pkg::ST_IDLE;
              end
            endcase
          end
        end
        flash_access_pkg::ST_WAIT: begin
          if (fl_done_in) begin
            if (op_reg == flash_access_pkg::OP_OPT_WRITE) begin
              readout_protect_out <= mem_wdata_out[0];
            end
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state    <= flash_access_pkg::ST_IDLE;
          end
        end
        flash_access_pkg::ST_RP_ERASE: begin
          if (fl_done_in) begin
            fl_opt_prog_out <= 1'b1;
            state           <= flash_access_pkg::ST_WAIT;
          end
        end
        flash_access_pkg::ST_READ: begin
          if (!fl_rd_out) begin
            link.tx_load <= 1'b1;
            link.tx_byte <= fl_rdata_in;
            done_out     <= 1'b1;
            busy_out     <= 1'b0;
            state        <= flash_access_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  a_sector0_locked:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (fl_prog_out || fl_sector_erase_out) && fl_sector_out == 2'h0 |-> op_ext)
    else $error("Sector zero written by application request.");

  a_rp_write_block:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (fl_prog_out || fl_sector_erase_out) && op_ext |-> !readout_protect_out)
    else $error("External write while read-out protected.");

  a_rp_read_zero:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    link.tx_load && readout_protect_out |-> link.tx_byte == 8'h00)
    else $error("Protected content sent on the link.");

  a_erase_before_clear:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fl_mass_erase_out && state == flash_access_pkg::ST_RP_ERASE |->
    readout_protect_out throughout (##[1:1000] fl_opt_prog_out))
    else $error("Protection cleared without preceding erase.");

  a_guard_armed:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fl_prog_out && !op_ext |-> $past(armed) && !armed)
    else $error("Application program started without arming.");

  a_sector_range:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fl_sector_erase_out |-> fl_sector_out <= MAX_SECTOR && busy_out)
    else $error("Erase aimed at a missing sector.");

  a_pins_reserved:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tool_present |=> icc_pins_reserved_out)
    else $error("Link pins not reserved with tool present.");

  a_reject_no_op:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == flash_access_pkg::ST_IDLE && req_valid && !permit |=>
    reject_out && !fl_prog_out && !fl_sector_erase_out && !fl_mass_erase_out)
    else $error("Refused request reached the flash.");

  a_ram_only_link:
  assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ram_we_out || ict_run_out |-> $past(icc_mode) && !readout_protect_out)
    else $error("RAM test access outside link mode.");

endmodule

// File: design/icc_link_if.sv
// Frame and reply signals between the serial link port and the access controller.
`timescale 1ns/1ps
interface icc_link_if;
  logic        frame_valid;
  logic [31:0] frame;
  logic        tx_load;
  logic [7:0]  tx_byte;
  logic        session;
  modport serial (output frame_valid, output frame, input tx_load, input tx_byte, input session);
  modport ctrl   (input frame_valid, input frame, output tx_load, output tx_byte, output session);
endinterface

// File: design/icc_serial_port.sv
// Two-wire in-circuit link: samples the tool's clock, shifts frames in, shifts reply bytes out.
`timescale 1ns/1ps
module icc_serial_port (
  input  wire logic    mclk_in,
  input  wire logic    rst_n_in,
  input  wire logic    icc_serial_clock_in,
  input  wire logic    icc_serial_data_in,
  output logic         icc_serial_data_out,
  output logic         icc_data_oe_n_out,
  icc_link_if.serial   link
);
  logic [1:0]  clk_sync;
  logic [1:0]  dat_sync;
  logic        clk_prev;
  logic [4:0]  bit_cnt;
  logic [31:0] shift;
  logic [7:0]  tx_shift;
  logic [3:0]  tx_cnt;
  logic        rise;
  logic        fall;
  logic        tx_busy;

  assign rise    = clk_sync[1] & ~clk_prev;
  assign fall    = ~clk_sync[1] & clk_prev;
  assign tx_busy = (tx_cnt != 4'h0) | ~icc_data_oe_n_out;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], icc_serial_clock_in};
      dat_sync <= {dat_sync[0], icc_serial_data_in};
      clk_prev <= clk_sync[1];
    end
  end

  // Data is taken on the tool's rising edge, most significant bit first.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !link.session) begin
      bit_cnt          <= 5'h0;
      shift            <= 32'h0000_0000;
      link.frame_valid <= 1'b0;
      link.frame       <= 32'h0000_0000;
    end else begin
      link.frame_valid <= 1'b0;
      if (rise && !tx_busy) begin
        shift   <= {shift[30:0], dat_sync[1]};
        bit_cnt <= bit_cnt + 5'h1;
        if (bit_cnt == 5'(flash_access_pkg::FRAME_BITS - 1)) begin
          link.frame_valid <= 1'b1;
          link.frame       <= {shift[30:0], dat_sync[1]};
        end
      end
    end
  end

  // shared data line
  // A reply is driven from falling edges so the tool can sample it on its rising edge.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !link.session) begin
      tx_shift            <= 8'h00;
      tx_cnt              <= 4'h0;
      icc_serial_data_out <= 1'b0;
      icc_data_oe_n_out   <= 1'b1;
    end else if (link.tx_load) begin
      tx_shift <= link.tx_byte;
      tx_cnt   <= 4'(flash_access_pkg::TX_BITS);
    end else if (fall) begin
      if (tx_cnt != 4'h0) begin
        icc_serial_data_out <= tx_shift[7];
        icc_data_oe_n_out   <= 1'b0;
        tx_shift            <= {tx_shift[6:0], 1'b0};
        tx_cnt              <= tx_cnt - 4'h1;
      end else begin
        icc_data_oe_n_out <= 1'b1;
      end
    end
  end

endmodule

// File: tb/flash_sector_protect_access_tb.sv
// Self-checking bench: tool model, flash macro model and application requests.
`timescale 1ns/1ps
module flash_sector_protect_access_tb;
  localparam int LOW_ADDR = 65536 - 16 * 1024;
  logic        mclk_in, rst_n_in, link_clk, link_data, pv_sel, tool_det, tool_socket_in, rp_option_in;
  logic        cpu_req_in, cpu_key_wr_in, fl_done_in;
  logic [7:0]  cpu_op_in, cpu_data_in, cpu_key_in, fl_rdata_in, mem_wdata_out;
  logic [15:0] cpu_addr_in, mem_addr_out;
  logic [1:0]  fl_sector_out;
  logic        fl_prog_out, fl_sector_erase_out, fl_mass_erase_out, fl_opt_prog_out, fl_rd_out, ram_we_out;
  logic        ict_run_out, busy_out, done_out, reject_out, readout_protect_out, icc_pins_reserved_out;
  logic        icc_serial_data_out, icc_data_oe_n_out;
  logic [7:0]  flash_mem [0:65535];
  int          fail_count, check_count, pend, lat, lo, hi;
  int          cnt_me, cnt_ram, cnt_run, cnt_done, cnt_rej, me_at_opt;

  flash_sector_protect_access #(.FLASH_KB(16)) flash_sector_protect_access_inst (
    .mclk_in, .rst_n_in, .icc_serial_clock_in(link_clk), .icc_serial_data_in(link_data),
    .programming_voltage_select_in(pv_sel), .tool_detect_in(tool_det), .tool_socket_in, .rp_option_in,
    .cpu_req_in, .cpu_op_in, .cpu_addr_in, .cpu_data_in, .cpu_key_wr_in, .cpu_key_in, .fl_done_in,
    .fl_rdata_in, .mem_addr_out, .mem_wdata_out, .fl_sector_out, .fl_prog_out, .fl_sector_erase_out,
    .fl_mass_erase_out, .fl_opt_prog_out, .fl_rd_out, .ram_we_out, .ict_run_out, .busy_out, .done_out,
    .reject_out, .readout_protect_out, .icc_pins_reserved_out, .icc_serial_data_out, .icc_data_oe_n_out);

  icc_tool_model icc_tool_model_inst (
    .mclk_in, .dev_data_in(icc_serial_data_out), .dev_oe_n_in(icc_data_oe_n_out),
    .clk_out(link_clk), .data_out(link_data), .mode_out(pv_sel), .present_out(tool_det));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // sector bounds of the flash macro model
  always @(posedge mclk_in) begin
    fl_done_in <= (pend == 1);
    if (pend != 0) pend <= pend - 1;
    fl_rdata_in <= fl_rd_out ? flash_mem[mem_addr_out] : ~fl_rdata_in;
    if (fl_prog_out) flash_mem[mem_addr_out] = mem_wdata_out;
    lo = fl_sector_out == 2'h0 ? 'hF000 : fl_sector_out == 2'h1 ? 'hE000 : LOW_ADDR;
    hi = fl_sector_out == 2'h0 ? 'hFFFF : fl_sector_out == 2'h1 ? 'hEFFF : 'hDFFF;
    if (fl_mass_erase_out) lo = LOW_ADDR;
    if (fl_mass_erase_out) hi = 'hFFFF;
    if (fl_sector_erase_out | fl_mass_erase_out) for (int a = lo; a <= hi; a++) flash_mem[a] = 8'hFF;
    if (fl_opt_prog_out) me_at_opt = cnt_me;
    if (fl_prog_out | fl_sector_erase_out | fl_mass_erase_out | fl_opt_prog_out) pend <= lat;
    cnt_me += fl_mass_erase_out;
    cnt_ram += ram_we_out;
    cnt_run += ict_run_out;
    cnt_done += done_out;
    cnt_rej += reject_out;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_resp(input int n, input int r, input int exp_rej);
    for (int i = 0; i < 400 && cnt_done + cnt_rej == n; i++) @(posedge mclk_in);
    repeat (2) @(posedge mclk_in);
    check(cnt_rej - r, exp_rej, "refusal count");
  endtask

  task automatic cpu_op(input logic key, input flash_access_pkg::op_type op, input logic [15:0] addr,
                        input logic [7:0] data,
                        input int exp_rej);
    int n;
    int r;
    n = cnt_done + cnt_rej;
    r = cnt_rej;
    if (key) begin
      @(posedge mclk_in);
      cpu_key_wr_in <= 1'b1;
      cpu_key_in <= flash_access_pkg::GUARD_KEY1;
      @(posedge mclk_in);
      cpu_key_in <= flash_access_pkg::GUARD_KEY2;
    end
    @(posedge mclk_in);
    cpu_key_wr_in <= 1'b0;
    cpu_req_in <= 1'b1;
    cpu_op_in <= op;
    cpu_addr_in <= addr;
    cpu_data_in <= data;
    @(posedge mclk_in);
    cpu_req_in <= 1'b0;
    wait_resp(n, r, exp_rej);
  endtask

  task automatic link_op(input flash_access_pkg::op_type op, input logic [15:0] addr, input logic [7:0] data,
                         input int exp_rej);
    int n;
    int r;
    n = cnt_done + cnt_rej;
    r = cnt_rej;
    icc_tool_model_inst.send_frame({op, addr, data});
    wait_resp(n, r, exp_rej);
  endtask

  task automatic link_read(input logic [15:0] addr, output logic [7:0] b);
    icc_tool_model_inst.send_frame({flash_access_pkg::OP_READ, addr, 8'h00});
    repeat (16) @(posedge mclk_in);
    icc_tool_model_inst.read_reply(b);
  endtask

  task automatic s_app_requests();
    lat = 2;
    cpu_op(1'b0, flash_access_pkg::OP_PROG, 16'hC000, 8'h5A, 1);
    cpu_op(1'b1, flash_access_pkg::OP_PROG, 16'hC000, 8'h5A, 0);
    check(flash_mem[16'hC000], 8'h5A, "app program");
    check(fl_sector_out, 2'h2, "sector index");
    cpu_op(1'b1, flash_access_pkg::OP_PROG, 16'hF000, 8'h11, 1);
    cpu_op(1'b1, flash_access_pkg::OP_SECT_ERASE, 16'hF800, 8'h00, 1);
    cpu_op(1'b1, flash_access_pkg::OP_MASS_ERASE, 16'hC000, 8'h00, 1);
    cpu_op(1'b1, flash_access_pkg::OP_PROG, 16'h8000, 8'h22, 1);
    check(flash_mem[16'hF000], 8'hF0, "locked sector kept");
  endtask

  task automatic s_sector_erase();
    lat = 40;
    cpu_op(1'b1, flash_access_pkg::OP_PROG, 16'hE010, 8'hA5, 0);
    cpu_op(1'b1, flash_access_pkg::OP_SECT_ERASE, 16'hE000, 8'h00, 0);
    check(fl_sector_out, 2'h1, "second sector index");
    check(flash_mem[16'hE010], 8'hFF, "sector erased");
    check(flash_mem[16'hC000], 8'h5A, "other sector kept");
    check(flash_mem[16'hFFFE], 8'h01, "vector sector kept");
    check(busy_out, 1'b0, "idle after done");
  endtask

  task automatic s_link_protected();
    logic [7:0] b;
    lat = 3;
    icc_tool_model_inst.attach();
    repeat (6) @(posedge mclk_in);
    check(icc_pins_reserved_out, 1'b1, "pins reserved");
    link_read(16'hC000, b);
    check(b, 8'h00, "protected read");
    link_op(flash_access_pkg::OP_PROG, 16'hD001, 8'h77, 1);
    check(flash_mem[16'hD001], 8'hD1, "protected write kept");
  endtask

  task automatic s_unprotect();
    int m;
    m = cnt_me;
    link_op(flash_access_pkg::OP_OPT_WRITE, 16'h0000, 8'h00, 0);
    for (int i = 0; i < 500 && readout_protect_out !== 1'b0; i++) @(posedge mclk_in);
    check(readout_protect_out, 1'b0, "protection removed");
    check(me_at_opt - m, 1, "erase before option");
    check(flash_mem[16'hC000], 8'hFF, "array erased");
  endtask

  task automatic s_link_full();
    logic [7:0] b;
    int r;
    lat = 25;
    link_op(flash_access_pkg::OP_PROG, 16'hF000, 8'h55, 0);
    link_read(16'hF000, b);
    check(b, 8'h55, "link read back");
    link_op(flash_access_pkg::OP_SECT_ERASE, 16'hF000, 8'h00, 0);
    check(flash_mem[16'hF000], 8'hFF, "link erase of sector 0");
    r = cnt_ram;
    link_op(flash_access_pkg::OP_RAM_WR, 16'h0100, 8'h9C, 0);
    check(cnt_ram - r, 1, "RAM byte written");
    check(mem_wdata_out, 8'h9C, "RAM data");
    r = cnt_run;
    link_op(flash_access_pkg::OP_RAM_RUN, 16'h0100, 8'h00, 0);
    check(cnt_run - r, 1, "test code started");
  endtask

  task automatic s_socket();
    tool_socket_in <= 1'b1;
    icc_tool_model_inst.set_mode(1'b0);
    repeat (6) @(posedge mclk_in);
    check(icc_pins_reserved_out, 1'b1, "socket pins reserved");
    link_op(flash_access_pkg::OP_RAM_WR, 16'h0100, 8'h3C, 1);
    link_op(flash_access_pkg::OP_PROG, 16'hF001, 8'h66, 0);
    check(flash_mem[16'hF001], 8'h66, "socket program");
  endtask

  initial begin
    repeat (30000) @(posedge mclk_in);
    fail_count++;
    end_of_test();
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    pend = 0;
    lat = 2;
    {cnt_me, cnt_ram, cnt_run, cnt_done, cnt_rej, me_at_opt} = '0;
    for (int a = 0; a < 65536; a++) flash_mem[a] = a[7:0] ^ a[15:8];
    {tool_socket_in, cpu_req_in, cpu_key_wr_in, fl_done_in} = '0;
    {cpu_op_in, cpu_data_in, cpu_key_in, fl_rdata_in, cpu_addr_in} = '0;
    rp_option_in = 1'b1;
    // reset driven by the bench
    rst_n_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check(readout_protect_out, 1'b1, "protection loaded");
    check(icc_data_oe_n_out, 1'b1, "data pin released");
    check(icc_pins_reserved_out, 1'b0, "pins free");
    s_app_requests();
    s_sector_erase();
    s_link_protected();
    s_unprotect();
    s_link_full();
    s_socket();
    end_of_test();
  end
endmodule

// File: tb/icc_tool_model.sv
// Programming tool model: link clock, frames, mode pins and reply reading.
`timescale 1ns/1ps
module icc_tool_model #(
  parameter int HALF = 16
) (
  input  wire logic mclk_in,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_n_in,
  output logic      clk_out,
  output logic      data_out,
  output logic      mode_out,
  output logic      present_out
);
  logic drive;
  logic val;
  logic last;

  initial begin
    clk_out = 1'b0;
    drive = 1'b0;
    val = 1'b0;
    last = 1'b0;
    mode_out = 1'b0;
    present_out = 1'b0;
  end

  // one shared line
  // A released line toggles every cycle, so a stale bit can never pass for a driven one.
  assign data_out = !dev_oe_n_in ? dev_data_in : (drive ? val : ~last);
  always @(posedge mclk_in) begin
    last <= data_out;
  end

  task automatic attach();
    @(posedge mclk_in);
    present_out <= 1'b1;
    mode_out <= 1'b1;
  endtask

  // Mode pin alone, for a tool that holds the part in a socket instead.
  task automatic set_mode(input logic m);
    @(posedge mclk_in);
    mode_out <= m;
  endtask

  task automatic send_frame(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      @(posedge mclk_in);
      clk_out <= 1'b0;
      drive <= 1'b1;
      val <= f[i];
      repeat (HALF) @(posedge mclk_in);
      clk_out <= 1'b1;
      repeat (HALF - 1) @(posedge mclk_in);
    end
    @(posedge mclk_in);
    drive <= 1'b0;
  endtask

  // The clock is left low afterwards and stands still until the next frame.
  task automatic read_reply(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_in);
      clk_out <= 1'b0;
      repeat (HALF) @(posedge mclk_in);
      b = {b[6:0], data_out};
      clk_out <= 1'b1;
      repeat (HALF - 1) @(posedge mclk_in);
    end
    @(posedge mclk_in);
    clk_out <= 1'b0;
    repeat (HALF) @(posedge mclk_in);
  endtask
endmodule
